// ---- core/output_synth_config_regs.sv ----
/*
  Output synthesizer configuration registers with a simple clock generator
  for the synthesizer clock pin.
  Assumes a same-clock register master that never overlaps strobes, and
  that the lower sixteen frame offset bits come from registers elsewhere.
*/
// Notes on behaviour
// R01: The six low bits of the upper offset register form bits 21:16 of the 22-bit frame pulse offset.
// R02: The coarse offset field counts whole 8 kHz frame periods of frame pulse delay.
// R03: For an E1-multiple sync clock the sixteen low offset bits count 262.144 MHz periods.
// R04: Drive enable bit 0 of register 0x50 drives the synthesizer clock pin, zero floats it.
// R05: Bit 7 of the enable register runs the synthesizer, zero shuts it off.
// R06: Run bit 0 of register 0x51 lets the clock toggle, zero holds it low.
// R07: Plan select bit 6 chooses the SONET/SDH plan at zero and the Ethernet plan at one.
// R08: Family bit 4 with the plan bit chooses SONET/SDH or Ethernet output frequencies.
// R09: Bit 5 of the run register picks the high-speed diff group at zero, low-speed at one.
// R10: The four-bit code in bits 3:0 of the frequency register sets the clock rate by a fixed table.
// R11: A two-bit field shifts the clock phase by zero, 90, 180 or 270 degrees.
// R12: The fine trim is a signed 8-bit count of 119.2 ps steps.
// R13: Software writes reserved bits only with their reset values.
`timescale 1ns/1ps
module output_synth_config_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Lower frame pulse offset bits
  input wire logic [15:0] fp_offset_low,
  // Decoded configuration
  output output_synth_pkg::synth_cfg_t cfg,
  // Synthesizer clock pin
  output logic synth_clk_out,
  output logic synth_clk_oe_n
);
  // ********************************************************
  // Register file
  // ********************************************************
  logic [7:0] fp_upper;
  logic [7:0] en_ctrl;
  logic [7:0] run_ctrl;
  logic [7:0] freq_sel;
  logic [7:0] quad_sel;
  logic [7:0] fine_sel;

  // Reserved bits are stored as written and read back unchanged.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fp_upper <= output_synth_pkg::FP_OFFSET_UPPER_RST;
      en_ctrl <= output_synth_pkg::SYNTH_ENABLE_RST;
      run_ctrl <= output_synth_pkg::SYNTH_RUN_RST;
      freq_sel <= output_synth_pkg::SYNTH_FREQ_RST;
      quad_sel <= output_synth_pkg::SYNTH_QUADRANT_RST;
      fine_sel <= output_synth_pkg::SYNTH_FINE_RST;
    end else if (reg_wr) begin
      if (reg_addr == output_synth_pkg::FP_OFFSET_UPPER_ADDR) begin
        fp_upper <= reg_wdata;
      end else if (reg_addr == output_synth_pkg::SYNTH_ENABLE_ADDR) begin
        en_ctrl <= reg_wdata;
      end else if (reg_addr == output_synth_pkg::SYNTH_RUN_ADDR) begin
        run_ctrl <= reg_wdata;
      end else if (reg_addr == output_synth_pkg::SYNTH_FREQ_ADDR) begin
        freq_sel <= reg_wdata;
      end else if (reg_addr == output_synth_pkg::SYNTH_QUADRANT_ADDR) begin
        quad_sel <= reg_wdata;
      end else if (reg_addr == output_synth_pkg::SYNTH_FINE_ADDR) begin
        fine_sel <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= output_synth_pkg::UNMAPPED_READ;
    end else if (reg_rd) begin
      if (reg_addr == output_synth_pkg::FP_OFFSET_UPPER_ADDR) begin
        reg_rdata <= fp_upper;
      end else if (reg_addr == output_synth_pkg::SYNTH_ENABLE_ADDR) begin
        reg_rdata <= en_ctrl;
      end else if (reg_addr == output_synth_pkg::SYNTH_RUN_ADDR) begin
        reg_rdata <= run_ctrl;
      end else if (reg_addr == output_synth_pkg::SYNTH_FREQ_ADDR) begin
        reg_rdata <= freq_sel;
      end else if (reg_addr == output_synth_pkg::SYNTH_QUADRANT_ADDR) begin
        reg_rdata <= quad_sel;
      end else if (reg_addr == output_synth_pkg::SYNTH_FINE_ADDR) begin
        reg_rdata <= fine_sel;
      end else begin
        reg_rdata <= output_synth_pkg::UNMAPPED_READ;
      end
    end
  end

  // ********************************************************
  // Decoded configuration
  // ********************************************************
  logic synth_en;
  logic run_en;
  assign synth_en = en_ctrl[output_synth_pkg::SYNTH_EN_BIT]; // R05
  assign run_en = run_ctrl[output_synth_pkg::RUN_BIT]; // R06

  always_comb begin
    cfg.fp_coarse_frames = fp_upper[output_synth_pkg::COARSE_MSB:0]; // R02
    cfg.fp_fine_units = fp_offset_low; // R03
    cfg.fp_offset = {fp_upper[output_synth_pkg::COARSE_MSB:0], fp_offset_low}; // R01
    cfg.synth_on = synth_en;
    cfg.ethernet_plan = run_ctrl[output_synth_pkg::PLAN_BIT]; // R07
    cfg.ethernet_family = run_ctrl[output_synth_pkg::FAMILY_BIT]; // R08
    cfg.diff_low_speed = run_ctrl[output_synth_pkg::DIFF_GROUP_BIT]; // R09
    cfg.freq_code = freq_sel[output_synth_pkg::FREQ_MSB:0]; // R10
    cfg.quadrant = quad_sel[output_synth_pkg::QUAD_MSB:0]; // R11
    cfg.fine_trim = $signed(fine_sel); // R12
  end

  // ********************************************************
  // Clock generator
  // ********************************************************
  // The table gives the length of one quarter period in system cycles. The
  // real analog rates cannot be made from a 200 MHz clock, so this is a
  // scaled stand-in that keeps the ordering of codes and plans.
  function automatic logic [7:0] quarter_len(input logic [3:0] code, input logic eth);
    logic [7:0] len;
    len = output_synth_pkg::QUARTER_MIN;
    if (eth) begin
      len = 8'h02 + {3'h0, code, 1'b0};
    end else begin
      len = 8'h01 + {4'h0, code};
    end
    return len;
  endfunction

  logic [7:0] quarter;
  logic [7:0] qcnt;
  logic [1:0] qidx;
  logic gen_run;
  // Only when both plan and family agree on Ethernet are Ethernet rates used.
  assign quarter = quarter_len(cfg.freq_code, cfg.ethernet_plan & cfg.ethernet_family); // R08 R10
  assign gen_run = synth_en & run_en;

  // A stopped generator restarts at the first quarter so that phase is known.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      qcnt <= 8'h00;
      qidx <= 2'h0;
    end else if (!gen_run) begin
      qcnt <= 8'h00;
      qidx <= 2'h0;
    end else if (qcnt >= quarter - output_synth_pkg::QUARTER_MIN) begin
      qcnt <= 8'h00;
      qidx <= qidx + 2'h1;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  logic [1:0] rel_quarter;
  assign rel_quarter = qidx - cfg.quadrant; // R11

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      synth_clk_out <= 1'b0;
    end else begin
      synth_clk_out <= gen_run & ~rel_quarter[1]; // R05 R06 R11
    end
  end

  assign synth_clk_oe_n = ~en_ctrl[output_synth_pkg::DRIVE_EN_BIT]; // R04

  // ********************************************************
  // Checks
  // ********************************************************
  sequence s_write_en(bit b);
    reg_wr && reg_addr == output_synth_pkg::SYNTH_ENABLE_ADDR && reg_wdata[0] == b;
  endsequence

  property p_drive;
    @(posedge clk_sys) disable iff (rst)
    s_write_en(1'b0) |=> synth_clk_oe_n ##0 (synth_clk_oe_n || reg_wr)[*1];
  endproperty
  a_drive: assert property (p_drive) else $error("pin driven after drive enable cleared"); // R04

  property p_off;
    @(posedge clk_sys) disable iff (rst)
    !synth_en ##1 !synth_en |-> !synth_clk_out && qcnt == 8'h00;
  endproperty
  a_off: assert property (p_off) else $error("synthesizer active while disabled"); // R05

  property p_run_low;
    @(posedge clk_sys) disable iff (rst)
    !run_en [*2] |-> !synth_clk_out;
  endproperty
  a_run_low: assert property (p_run_low) else $error("clock not held low when stopped"); // R06

  sequence s_quad_start;
    gen_run && qcnt == 8'h00 && qidx == cfg.quadrant;
  endsequence

  property p_quad;
    @(posedge clk_sys) disable iff (rst)
    s_quad_start ##1 gen_run |-> synth_clk_out;
  endproperty
  a_quad: assert property (p_quad) else $error("clock low in its first shifted quarter"); // R11

  property p_offset;
    @(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == output_synth_pkg::FP_OFFSET_UPPER_ADDR
      |=> cfg.fp_offset[21:16] == $past(reg_wdata[5:0]) && cfg.fp_coarse_frames == cfg.fp_offset[21:16];
  endproperty
  a_offset: assert property (p_offset) else $error("upper offset bits not taken"); // R01 R02

  property p_plan;
    @(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == output_synth_pkg::SYNTH_RUN_ADDR
      |=> cfg.ethernet_plan == $past(reg_wdata[6]) && cfg.ethernet_family == $past(reg_wdata[4])
          && cfg.diff_low_speed == $past(reg_wdata[5]);
  endproperty
  a_plan: assert property (p_plan) else $error("plan, family or group bit not taken"); // R07 R08 R09

  property p_period;
    @(posedge clk_sys) disable iff (rst)
    gen_run && qcnt != 8'h00 && $stable(quarter) |-> qcnt < quarter;
  endproperty
  a_period: assert property (p_period) else $error("quarter counter beyond table length"); // R10

  property p_trim;
    @(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == output_synth_pkg::SYNTH_FINE_ADDR |=> cfg.fine_trim == $signed($past(reg_wdata));
  endproperty
  a_trim: assert property (p_trim) else $error("fine trim not taken as signed"); // R12

  property p_read;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == output_synth_pkg::SYNTH_FREQ_ADDR |=> reg_rdata == $past(freq_sel);
  endproperty
  a_read: assert property (p_read) else $error("frequency register read wrong"); // R10

  // Lists the offsets that hold a register; a read anywhere else must
  // return the fixed unmapped value rather than stale data.
  function automatic logic addr_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == output_synth_pkg::FP_OFFSET_UPPER_ADDR) begin
      hit = 1'b1;
    end else if (a == output_synth_pkg::SYNTH_ENABLE_ADDR) begin
      hit = 1'b1;
    end else if (a == output_synth_pkg::SYNTH_RUN_ADDR) begin
      hit = 1'b1;
    end else if (a == output_synth_pkg::SYNTH_FREQ_ADDR) begin
      hit = 1'b1;
    end else if (a == output_synth_pkg::SYNTH_QUADRANT_ADDR) begin
      hit = 1'b1;
    end else if (a == output_synth_pkg::SYNTH_FINE_ADDR) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  property p_rd_unmapped;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && !addr_mapped(reg_addr) |=> reg_rdata == output_synth_pkg::UNMAPPED_READ;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  // Software may pick the read data up late, so it must stand until the next read.
  property p_rd_idle;
    @(posedge clk_sys) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data changed without a read");

  property p_read_upper;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == output_synth_pkg::FP_OFFSET_UPPER_ADDR |=> reg_rdata == $past(fp_upper);
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper offset register read wrong"); // R01

  property p_read_enable;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == output_synth_pkg::SYNTH_ENABLE_ADDR |=> reg_rdata == $past(en_ctrl);
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("enable register read wrong"); // R05

  property p_read_run;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == output_synth_pkg::SYNTH_RUN_ADDR |=> reg_rdata == $past(run_ctrl);
  endproperty
  a_read_run: assert property (p_read_run) else $error("run register read wrong"); // R06

  property p_read_quad;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == output_synth_pkg::SYNTH_QUADRANT_ADDR |=> reg_rdata == $past(quad_sel);
  endproperty
  a_read_quad: assert property (p_read_quad) else $error("quadrant register read wrong"); // R11

  property p_read_fine;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == output_synth_pkg::SYNTH_FINE_ADDR |=> reg_rdata == $past(fine_sel);
  endproperty
  a_read_fine: assert property (p_read_fine) else $error("fine trim register read wrong"); // R12

  property p_synth_take;
    @(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == output_synth_pkg::SYNTH_ENABLE_ADDR |=> cfg.synth_on == $past(reg_wdata[7]);
  endproperty
  a_synth_take: assert property (p_synth_take) else $error("synthesizer enable bit not taken"); // R05

  property p_drive_on;
    @(posedge clk_sys) disable iff (rst)
    s_write_en(1'b1) |=> !synth_clk_oe_n;
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("pin floats after drive enable set"); // R04

  property p_freq_take;
    @(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == output_synth_pkg::SYNTH_FREQ_ADDR |=> cfg.freq_code == $past(reg_wdata[3:0]);
  endproperty
  a_freq_take: assert property (p_freq_take) else $error("frequency code not taken"); // R10

  property p_quad_take;
    @(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == output_synth_pkg::SYNTH_QUADRANT_ADDR |=> cfg.quadrant == $past(reg_wdata[1:0]);
  endproperty
  a_quad_take: assert property (p_quad_take) else $error("quadrant field not taken"); // R11

  property p_fine_low;
    @(posedge clk_sys) disable iff (rst)
    cfg.fp_fine_units == fp_offset_low && cfg.fp_offset[15:0] == fp_offset_low;
  endproperty
  a_fine_low: assert property (p_fine_low) else $error("low offset bits not passed through"); // R03

  sequence s_stop_write;
    reg_wr && reg_addr == output_synth_pkg::SYNTH_RUN_ADDR && !reg_wdata[output_synth_pkg::RUN_BIT];
  endsequence

  property p_stop;
    @(posedge clk_sys) disable iff (rst)
    s_stop_write |=> ##1 !synth_clk_out;
  endproperty
  a_stop: assert property (p_stop) else $error("clock not low one cycle after stop"); // R06

  // A restart with no phase shift must show the high half at once.
  sequence s_restart;
    !gen_run ##1 (gen_run && cfg.quadrant == 2'h0);
  endsequence

  property p_start;
    @(posedge clk_sys) disable iff (rst)
    s_restart |=> synth_clk_out;
  endproperty
  a_start: assert property (p_start) else $error("clock not high after restart"); // R06
endmodule

// ---- core/output_synth_pkg.sv ----
/*
  Constants and carrier types for the output synthesizer configuration block.
  Assumes an 8-bit register port on the same clock as the block.
*/
package output_synth_pkg;
  // ********************************************************
  // Register offsets and values after reset
  // ********************************************************
  localparam logic [7:0] FP_OFFSET_UPPER_ADDR = 8'h42;
  localparam logic [7:0] SYNTH_ENABLE_ADDR = 8'h50;
  localparam logic [7:0] SYNTH_RUN_ADDR = 8'h51;
  localparam logic [7:0] SYNTH_FREQ_ADDR = 8'h52;
  localparam logic [7:0] SYNTH_QUADRANT_ADDR = 8'h53;
  localparam logic [7:0] SYNTH_FINE_ADDR = 8'h55;
  localparam logic [7:0] FP_OFFSET_UPPER_RST = 8'h00;
  localparam logic [7:0] SYNTH_ENABLE_RST = 8'h8f;
  localparam logic [7:0] SYNTH_RUN_RST = 8'h0f;
  localparam logic [7:0] SYNTH_FREQ_RST = 8'h42;
  localparam logic [7:0] SYNTH_QUADRANT_RST = 8'h00;
  localparam logic [7:0] SYNTH_FINE_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int DRIVE_EN_BIT = 0;
  localparam int SYNTH_EN_BIT = 7;
  localparam int RUN_BIT = 0;
  localparam int FAMILY_BIT = 4;
  localparam int DIFF_GROUP_BIT = 5;
  localparam int PLAN_BIT = 6;
  localparam int COARSE_MSB = 5;
  localparam int FREQ_MSB = 3;
  localparam int QUAD_MSB = 1;
  // ********************************************************
  // Units of the offset and trim values, and quarter length constants
  // ********************************************************
  localparam int FRAME_RATE_HZ = 8000;
  localparam int FINE_UNIT_KHZ = 262144;
  localparam int TRIM_STEP_FS = 119200;
  localparam int QUARTER_W = 8;
  localparam logic [7:0] QUARTER_MIN = 8'h01;
  typedef struct packed {
    logic [21:0] fp_offset;
    logic [5:0] fp_coarse_frames;
    logic [15:0] fp_fine_units;
    logic synth_on;
    logic ethernet_plan;
    logic ethernet_family;
    logic diff_low_speed;
    logic [3:0] freq_code;
    logic [1:0] quadrant;
    logic signed [7:0] fine_trim;
  } synth_cfg_t;
endpackage

// ---- tb/output_synth_config_regs_tb.sv ----
/*
  Self-checking bench for the output synthesizer configuration registers.
  Assumes the register port, decoded configuration and clock pin described in the package.
*/
`timescale 1ns/1ps
module output_synth_config_regs_tb;
  // ********************************************************
  // Signals and instance
  // ********************************************************
  logic clk_sys;
  logic rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [15:0] fp_offset_low;
  output_synth_pkg::synth_cfg_t cfg;
  logic synth_clk_out;
  logic synth_clk_oe_n;
  int bad_count;
  int checks;
  logic [7:0] adr [6] = '{8'h42, 8'h50, 8'h51, 8'h52, 8'h53, 8'h55};
  logic [7:0] rv [6] = '{8'h00, 8'h8f, 8'h0f, 8'h42, 8'h00, 8'h00};
  // Only defined fields are flipped; reserved bits keep their reset value.
  logic [7:0] msk [6] = '{8'h3f, 8'h81, 8'h71, 8'h0f, 8'h03, 8'hff};

  output_synth_config_regs dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fp_offset_low(fp_offset_low), .cfg(cfg),
    .synth_clk_out(synth_clk_out), .synth_clk_oe_n(synth_clk_oe_n));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic chk(input logic [21:0] got, input logic [21:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(22'(reg_rdata), 22'(exp), "read data");
  endtask
  // Counts cycles until the pin reaches the given level, bounded so a dead generator cannot hang the run.
  task automatic wait_level(input logic lvl, output int d);
    d = 0;
    while (synth_clk_out !== lvl && d < 200) begin
      @(posedge clk_sys);
      #1;
      d++;
    end
  endtask
  // A partial phase after a change is skipped by waiting for a fresh low first.
  task automatic high_len(input int exp, input string msg);
    int d;
    int h;
    wait_level(1'b0, d);
    wait_level(1'b1, d);
    wait_level(1'b0, h);
    chk(22'(h), 22'(exp), msg);
  endtask
  task automatic stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic test_reset;
    for (int i = 0; i < 6; i++) rd_chk(adr[i], rv[i]);
    rd_chk(8'h54, output_synth_pkg::UNMAPPED_READ);
    chk(22'(synth_clk_oe_n), 22'h0, "pin driven after reset");
    chk(22'(cfg.freq_code), 22'h2, "freq code after reset");
    $display("reset test done");
  endtask
  task automatic test_regs;
    for (int i = 0; i < 6; i++) wr(adr[i], rv[i] ^ msk[i]);
    wr(8'h54, 8'haa);
    for (int i = 0; i < 6; i++) rd_chk(adr[i], rv[i] ^ msk[i]);
    rd_chk(8'h54, output_synth_pkg::UNMAPPED_READ);
    for (int i = 0; i < 6; i++) wr(adr[i], rv[i]);
    $display("register test done");
  endtask
  task automatic test_cfg;
    fp_offset_low <= 16'h1234;
    wr(8'h42, 8'h2a);
    chk(cfg.fp_offset, 22'h2a1234, "offset");
    chk(22'(cfg.fp_coarse_frames), 22'h2a, "coarse");
    chk(22'(cfg.fp_fine_units), 22'h1234, "fine units");
    wr(8'h55, 8'h80);
    chk(22'(cfg.fine_trim < 0), 22'h1, "trim sign");
    chk(22'($unsigned(cfg.fine_trim)), 22'h80, "trim");
    for (int i = 0; i < 8; i++) begin
      wr(8'h51, {1'b0, 3'(i), 4'hf});
      chk(22'(cfg.ethernet_family), 22'(i & 1), "family");
      chk(22'(cfg.diff_low_speed), 22'((i >> 1) & 1), "diff group");
      chk(22'(cfg.ethernet_plan), 22'((i >> 2) & 1), "plan");
    end
    wr(8'h51, 8'h0f);
    wr(8'h50, 8'h8e);
    chk(22'(synth_clk_oe_n), 22'h1, "pin floats");
    wr(8'h50, 8'h0f);
    chk(22'(cfg.synth_on), 22'h0, "synth off");
    @(posedge clk_sys);
    #1;
    chk(22'(synth_clk_out), 22'h0, "out low when off");
    wr(8'h50, 8'h8f);
    chk(22'(synth_clk_oe_n), 22'h0, "pin driven");
    $display("config test done");
  endtask
  task automatic test_clock;
    int d0;
    int d;
    int h;
    high_len(6, "high for code 2");
    wr(8'h52, 8'h40);
    high_len(2, "high for code 0");
    wr(8'h52, 8'h41);
    wr(8'h51, 8'h5f);
    high_len(8, "ethernet high");
    wr(8'h51, 8'h4f);
    high_len(4, "plan alone stays sonet");
    wr(8'h51, 8'h0f);
    wr(8'h52, 8'h42);
    for (int k = 0; k < 4; k++) begin
      wr(8'h51, 8'h0e);
      @(posedge clk_sys);
      #1;
      chk(22'(synth_clk_out), 22'h0, "held low when stopped");
      wr(8'h53, 8'(k));
      chk(22'(cfg.quadrant), 22'(k), "quadrant field");
      wr(8'h51, 8'h0f);
      wait_level(1'b1, d);
      wait_level(1'b0, h);
      if (k == 0) d0 = d;
      // At 270 degrees the high half wraps across the restart: one quarter is high at once.
      chk(22'(d), 22'((k == 3) ? d0 : d0 + 3 * k), "quarter delay");
      chk(22'(h), 22'((k == 3) ? 3 : 6), "first high span");
    end
    wr(8'h53, 8'h00);
    $display("clock test done");
  endtask
  // ********************************************************
  // Main sequence and watchdog
  // ********************************************************
  initial begin
    bad_count = 0;
    checks = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fp_offset_low = 16'h0000;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset();
    test_regs();
    test_cfg();
    test_clock();
    stop_test();
  end
  // The tests take a few hundred cycles; this margin only cuts a hang.
  initial begin
    #200us;
    bad_count++;
    stop_test();
  end
endmodule
